// file: reset_timeout_sequencer_map.vh
`ifndef RESET_TIMEOUT_SEQUENCER_MAP_VH
`define RESET_TIMEOUT_SEQUENCER_MAP_VH

// Timing base
`define CLK_PERIOD_NS      4
`define MCLK_KHZ           250000
`define POWERUP_DELAY_TIMER_TIME_MS       72
`define OST_CYCLES         1024
`define FAST_KHZ           4000
`define SLOW_KHZ           37
`define MASTER_CLEAR_PIN_FILT_NS       100
`define BOD_MIN_NS         100

// Register indices and byte addresses
`define POWER_CONTROL_STATUS_IDX           10'h08e
`define STAT_IDX           10'h08f
`define POWER_CONTROL_STATUS_ADDR          {`POWER_CONTROL_STATUS_IDX, 2'b00}
`define STAT_ADDR          {`STAT_IDX, 2'b00}

// Power control/status fields
`define POWER_CONTROL_STATUS_BOD_BIT       0
`define POWER_CONTROL_STATUS_POR_BIT       1
`define POWER_CONTROL_STATUS_DSS_BIT       3
`define POWER_CONTROL_STATUS_DSS_RST       1'b1
`define POWER_CONTROL_STATUS_POR_RST       1'b0
`define POWER_CONTROL_STATUS_BOD_RST       1'b0

// Sequencer status fields
`define STAT_TO_BIT        0
`define STAT_PD_BIT        1
`define STAT_ST_LSB        4
`define STAT_ST_MSB        6
`define STAT_HOLD_BIT      7

// Oscillator modes from the configuration word
`define MODE_LP            3'h0
`define MODE_XT            3'h1
`define MODE_HS            3'h2
`define MODE_EC            3'h3
`define MODE_INTERNAL_RC_MODE         3'h4
`define MODE_ER            3'h5

`endif

// file: reset_timeout_sequencer.v
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`include "reset_timeout_sequencer_map.vh"

module reset_timeout_sequencer #(
  parameter [31:0] POWERUP_DELAY_TIMER_CYCLES = `POWERUP_DELAY_TIMER_TIME_MS * `MCLK_KHZ,
  parameter [31:0] SLOW_DIV    = `MCLK_KHZ / `SLOW_KHZ,
  parameter [31:0] FAST_DIV    = `MCLK_KHZ / `FAST_KHZ,
  parameter [31:0] OST_COUNT   = `OST_CYCLES,
  parameter integer POWERUP_DELAY_TIMER_W     = 25,
  parameter integer DIV_W      = 13
)(
  // Clock and power-on reset
  input  wire        mclk,
  input  wire        rst_n,
  // Supply monitor and reset sources
  input  wire        brownout_low,
  input  wire        master_clear_pin_n,
  input  wire        watchdog_timeout,
  input  wire        wake_irq,
  input  wire        sleep_req,
  // Configuration word
  input  wire [2:0]  osc_mode,
  input  wire        powerup_timer_disable,
  input  wire        brownout_enable,
  input  wire        clock_output_cfg,
  // Oscillator pins
  input  wire        clock_input_pin,
  input  wire        pin_two_gpio_out,
  input  wire        pin_two_gpio_oe,
  output reg         clock_pin_two_out_q,
  output reg         clock_pin_two_oe_q,
  // Core control
  output reg         core_hold_q,
  output reg         reg_clear_q,
  output reg         sys_tick_q,
  output reg         timeout_flag_q,
  output reg         powerdown_flag_q,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // States and derived counts

  localparam [2:0] ST_SUPPLY = 3'b000;
  localparam [2:0] ST_POWERUP_DELAY_TIMER   = 3'b001;
  localparam [2:0] ST_OST    = 3'b010;
  localparam [2:0] ST_HOLD   = 3'b011;
  localparam [2:0] ST_RUN    = 3'b100;
  localparam [2:0] ST_SLEEP  = 3'b101;
  localparam [2:0] ST_WAKE   = 3'b110;

  // Least times round up to whole cycles
  localparam [31:0] MASTER_CLEAR_PIN_FILT32 =
    (`MASTER_CLEAR_PIN_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [31:0] BOD_MIN32 =
    (`BOD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [7:0] MASTER_CLEAR_PIN_FILT = MASTER_CLEAR_PIN_FILT32[7:0];
  localparam [7:0] BOD_MIN   = BOD_MIN32[7:0];

  localparam [31:0] POWERUP_DELAY_TIMER_LAST32 = POWERUP_DELAY_TIMER_CYCLES - 32'h1;
  localparam [31:0] OST_LAST32  = OST_COUNT - 32'h1;
  localparam [31:0] SLOW_LAST32 = SLOW_DIV - 32'h1;
  localparam [31:0] FAST_LAST32 = FAST_DIV - 32'h1;
  localparam [POWERUP_DELAY_TIMER_W-1:0] POWERUP_DELAY_TIMER_LAST = POWERUP_DELAY_TIMER_LAST32[POWERUP_DELAY_TIMER_W-1:0];
  localparam [10:0]       OST_LAST  = OST_LAST32[10:0];
  localparam [DIV_W-1:0]  SLOW_LAST = SLOW_LAST32[DIV_W-1:0];
  localparam [DIV_W-1:0]  FAST_LAST = FAST_LAST32[DIV_W-1:0];

  reg  [2:0]        state_q;
  reg  [POWERUP_DELAY_TIMER_W-1:0] powerup_delay_timer_cnt_q;
  reg  [10:0]       ost_cnt_q;
  reg               cause_pwr_q;
  reg               dss_q;
  reg               por_flag_q;
  reg               bod_flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  wire rc_mode      = (osc_mode == `MODE_ER) | (osc_mode == `MODE_INTERNAL_RC_MODE);
  wire crystal_mode = (osc_mode == `MODE_LP) | (osc_mode == `MODE_XT) |
                      (osc_mode == `MODE_HS);
  wire clock_output_mode  = rc_mode | (osc_mode == `MODE_EC);

  ////////////////////////////////////////////////////////////////////////////
  // Master clear noise filter

  reg       master_clear_pin_prev_q;
  reg [7:0] master_clear_pin_cnt_q;
  reg       master_clear_pin_low_q;

  // The level must stay put for the whole window before it is believed
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_clear_pin_prev_q <= 1'b1;
      master_clear_pin_cnt_q  <= 8'h00;
      master_clear_pin_low_q  <= 1'b0;
    end
    else
    begin
      master_clear_pin_prev_q <= master_clear_pin_n;
      if (master_clear_pin_n != master_clear_pin_prev_q)
        master_clear_pin_cnt_q <= 8'h00;
      else if (master_clear_pin_cnt_q != MASTER_CLEAR_PIN_FILT)
        master_clear_pin_cnt_q <= master_clear_pin_cnt_q + 8'h01;
      else
        master_clear_pin_low_q <= ~master_clear_pin_prev_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brown-out qualification

  reg [7:0] bod_cnt_q;
  wire      supply_low = brownout_enable & brownout_low;
  wire      bod_trip   = supply_low & (bod_cnt_q == BOD_MIN);

  // Only a dip longer than the minimum time trips; a slow decline alone never
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      bod_cnt_q <= 8'h00;
    else if (!supply_low)
      bod_cnt_q <= 8'h00;
    else if (bod_cnt_q != BOD_MIN)
      bod_cnt_q <= bod_cnt_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock enable and clock output

  reg             osc_prev_q;
  reg [DIV_W-1:0] div_cnt_q;
  reg [1:0]       quarter_q;

  wire             osc_rise = clock_input_pin & ~osc_prev_q;
  wire [DIV_W-1:0] div_last = dss_q ? FAST_LAST : SLOW_LAST;
  // Compare with >= so a switch to the short period mid-count never overruns
  wire             div_wrap = (div_cnt_q >= div_last);
  wire             sys_tick = rc_mode ? div_wrap : osc_rise;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_prev_q <= 1'b0;
      div_cnt_q  <= {DIV_W{1'b0}};
      quarter_q  <= 2'b00;
      sys_tick_q <= 1'b0;
    end
    else
    begin
      osc_prev_q <= clock_input_pin;
      if (div_wrap)
        div_cnt_q <= {DIV_W{1'b0}};
      else
        div_cnt_q <= div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      sys_tick_q <= sys_tick;
      if (sys_tick)
        quarter_q <= quarter_q + 2'b01;
    end
  end

  // Pin two carries the crystal in crystal modes, so it is never driven then
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_pin_two_out_q <= 1'b0;
      clock_pin_two_oe_q  <= 1'b0;
    end
    else if (clock_output_mode && clock_output_cfg)
    begin
      clock_pin_two_out_q <= quarter_q[1];
      clock_pin_two_oe_q  <= 1'b1;
    end
    else if (rc_mode)
    begin
      clock_pin_two_out_q <= pin_two_gpio_out;
      clock_pin_two_oe_q  <= pin_two_gpio_oe;
    end
    else
    begin
      clock_pin_two_out_q <= 1'b0;
      clock_pin_two_oe_q  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire hit_power_control_status = (paddr == `POWER_CONTROL_STATUS_ADDR);
  wire hit_stat = (paddr == `STAT_ADDR);
  wire apb_wr   = psel & penable & pready & pwrite & hit_power_control_status;

  wire [31:0] power_control_status_rd = {28'h0000000, dss_q, 1'b0, por_flag_q, bod_flag_q};
  wire [31:0] stat_rd = {24'h000000, core_hold_q, state_q, 2'b00,
                         powerdown_flag_q, timeout_flag_q};

  // Answer is registered in the setup cycle, so every access has no wait
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(hit_power_control_status | hit_stat);
      if (psel && !penable && !pwrite)
        prdata <= hit_power_control_status ? power_control_status_rd : (hit_stat ? stat_rd : 32'h00000000);
      else
        prdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q          <= ST_SUPPLY;
      powerup_delay_timer_cnt_q       <= {POWERUP_DELAY_TIMER_W{1'b0}};
      ost_cnt_q        <= 11'h000;
      cause_pwr_q      <= 1'b1;
      timeout_flag_q   <= 1'b1;
      powerdown_flag_q <= 1'b1;
      por_flag_q       <= `POWER_CONTROL_STATUS_POR_RST;
      bod_flag_q       <= `POWER_CONTROL_STATUS_BOD_RST;
      dss_q            <= `POWER_CONTROL_STATUS_DSS_RST;
    end
    else
    begin
      // Software write first; any hardware event below overrides it
      if (apb_wr)
      begin
        dss_q      <= pwdata[`POWER_CONTROL_STATUS_DSS_BIT];
        por_flag_q <= pwdata[`POWER_CONTROL_STATUS_POR_BIT];
        bod_flag_q <= pwdata[`POWER_CONTROL_STATUS_BOD_BIT];
      end

      if (bod_trip)
      begin
        state_q     <= ST_SUPPLY;
        cause_pwr_q <= 1'b1;
        bod_flag_q  <= 1'b0;
        dss_q       <= `POWER_CONTROL_STATUS_DSS_RST;
        timeout_flag_q   <= 1'b1;
        powerdown_flag_q <= 1'b1;
      end
      else
      begin
        case (state_q)
          ST_SUPPLY:
          begin
            if (!supply_low)
            begin
              powerup_delay_timer_cnt_q <= POWERUP_DELAY_TIMER_LAST;
              ost_cnt_q  <= OST_LAST;
              if (cause_pwr_q && !powerup_timer_disable)
                state_q <= ST_POWERUP_DELAY_TIMER;
              else if (cause_pwr_q && crystal_mode)
                state_q <= ST_OST;
              else
                state_q <= ST_HOLD;
            end
          end
          ST_POWERUP_DELAY_TIMER:
          begin
            if (supply_low)
              state_q <= ST_SUPPLY;
            else if (powerup_delay_timer_cnt_q == {POWERUP_DELAY_TIMER_W{1'b0}})
              state_q <= crystal_mode ? ST_OST : ST_HOLD;
            else
              powerup_delay_timer_cnt_q <= powerup_delay_timer_cnt_q - {{(POWERUP_DELAY_TIMER_W-1){1'b0}}, 1'b1};
          end
          ST_OST:
          begin
            if (supply_low)
              state_q <= ST_SUPPLY;
            else if (osc_rise)
            begin
              if (ost_cnt_q == 11'h000)
                state_q <= ST_HOLD;
              else
                ost_cnt_q <= ost_cnt_q - 11'h001;
            end
          end
          ST_HOLD:
          begin
            // Timeouts ran from power-on; only master clear is left to wait on
            if (!master_clear_pin_low_q)
              state_q <= ST_RUN;
          end
          ST_RUN:
          begin
            if (master_clear_pin_low_q)
            begin
              state_q     <= ST_SUPPLY;
              cause_pwr_q <= 1'b0;
              dss_q       <= `POWER_CONTROL_STATUS_DSS_RST;
            end
            else if (watchdog_timeout)
            begin
              state_q        <= ST_SUPPLY;
              cause_pwr_q    <= 1'b0;
              dss_q          <= `POWER_CONTROL_STATUS_DSS_RST;
              timeout_flag_q <= 1'b0;
            end
            else if (sleep_req)
            begin
              state_q          <= ST_SLEEP;
              timeout_flag_q   <= 1'b1;
              powerdown_flag_q <= 1'b0;
            end
          end
          ST_SLEEP:
          begin
            ost_cnt_q <= OST_LAST;
            if (master_clear_pin_low_q)
            begin
              state_q          <= ST_SUPPLY;
              cause_pwr_q      <= 1'b0;
              dss_q            <= `POWER_CONTROL_STATUS_DSS_RST;
              timeout_flag_q   <= 1'b1;
              powerdown_flag_q <= 1'b0;
            end
            else if (watchdog_timeout || wake_irq)
            begin
              state_q          <= crystal_mode ? ST_WAKE : ST_RUN;
              timeout_flag_q   <= ~watchdog_timeout;
              powerdown_flag_q <= 1'b0;
            end
          end
          ST_WAKE:
          begin
            // Registers kept: the core only waits for its crystal here
            if (master_clear_pin_low_q)
            begin
              state_q          <= ST_SUPPLY;
              cause_pwr_q      <= 1'b0;
              dss_q            <= `POWER_CONTROL_STATUS_DSS_RST;
              timeout_flag_q   <= 1'b1;
              powerdown_flag_q <= 1'b0;
            end
            else if (osc_rise)
            begin
              if (ost_cnt_q == 11'h000)
                state_q <= ST_RUN;
              else
                ost_cnt_q <= ost_cnt_q - 11'h001;
            end
          end
          default:
            state_q <= ST_SUPPLY;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core controls

  wire full_reset_d = (state_q == ST_SUPPLY) | (state_q == ST_POWERUP_DELAY_TIMER) |
                      (state_q == ST_OST) | (state_q == ST_HOLD);

  // Never-reset registers simply do not take reg_clear_q
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_clear_q <= 1'b1;
      core_hold_q <= 1'b1;
    end
    else
    begin
      reg_clear_q <= full_reset_d;
      core_hold_q <= (state_q != ST_RUN);
    end
  end

endmodule

// file: reset_timeout_sequencer_checker.sv
`timescale 1ns/1ns
module reset_timeout_sequencer_checker (
  // Clock and reset
  input wire        mclk,
  input wire        rst_n,
  // Reset sources and configuration
  input wire        brownout_low,
  input wire        brownout_enable,
  input wire        master_clear_pin_n,
  input wire        watchdog_timeout,
  input wire        sleep_req,
  input wire [2:0]  osc_mode,
  input wire        clock_output_cfg,
  // Sequencer outputs
  input wire        core_hold_q,
  input wire        reg_clear_q,
  input wire        clock_pin_two_oe_q,
  input wire        timeout_flag_q,
  input wire        powerdown_flag_q,
  // Register bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [5:0] low_cnt_q;
  logic       por_one_q;
  wire        calm = !brownout_low && !watchdog_timeout && !sleep_req;
  wire        live = master_clear_pin_n && !brownout_low;
  wire        power_control_status = psel && penable && pready && paddr == 12'h238;
  ////////////////////////////////////////////////////////////////////////////////
  // Software may clear the power-on flag itself, so a write re-arms the tracker
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      low_cnt_q <= 6'h00;
      por_one_q <= 1'b0;
    end
    else
    begin
      low_cnt_q <= (brownout_low && brownout_enable) ?
                   low_cnt_q + {5'h00, low_cnt_q != 6'h3f} : 6'h00;
      if (power_control_status && pwrite)
        por_one_q <= pwdata[1];
      else if (power_control_status && prdata[1])
        por_one_q <= 1'b1;
    end
  ////////////////////////////////////////////////////////////////////////////////
  property p_po_hold;
    $rose(rst_n) |-> core_hold_q && reg_clear_q;
  endproperty
  a_po_hold: assert property (p_po_hold) else $error("core free at power-on");
  property p_glitch;
    (calm && !core_hold_q)[*4] ##0 master_clear_pin_n ##1
    (calm && !master_clear_pin_n)[*8] |-> !core_hold_q;
  endproperty
  a_glitch: assert property (p_glitch) else $error("short clear pulse reset");
  property p_release;
    $fell(core_hold_q) |-> master_clear_pin_n && $past(master_clear_pin_n);
  endproperty
  a_release: assert property (p_release) else $error("run with clear low");
  property p_por_flag;
    power_control_status && !pwrite && por_one_q |-> prdata[1];
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("poweron flag lost");
  property p_wdt;
    watchdog_timeout && !core_hold_q && live |-> ##[1:4] !timeout_flag_q;
  endproperty
  a_wdt: assert property (p_wdt) else $error("timeout flag not cleared");
  property p_sleep;
    sleep_req && !core_hold_q && live && !watchdog_timeout
      |-> ##[1:4] timeout_flag_q && !powerdown_flag_q;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  property p_wake;
    watchdog_timeout && core_hold_q && !powerdown_flag_q && live
      |-> ##[1:4] !timeout_flag_q && !powerdown_flag_q;
  endproperty
  a_wake: assert property (p_wake) else $error("wake flags wrong");
  property p_bod;
    low_cnt_q == 6'h28 |-> core_hold_q && reg_clear_q;
  endproperty
  a_bod: assert property (p_bod) else $error("no brown-out reset");
  property p_clock_output;
    (osc_mode == 3'h5 && clock_output_cfg)[*4] |-> clock_pin_two_oe_q;
  endproperty
  a_clock_output: assert property (p_clock_output) else $error("clock output off");
  c_sleep: cover property (sleep_req && !core_hold_q);
  c_run: cover property ($fell(core_hold_q));
  c_bod: cover property (low_cnt_q == 6'h28);
endmodule
bind reset_timeout_sequencer reset_timeout_sequencer_checker chk_i (.mclk, .rst_n,
  .brownout_low, .brownout_enable, .master_clear_pin_n, .watchdog_timeout, .sleep_req,
  .osc_mode, .clock_output_cfg, .core_hold_q, .reg_clear_q, .clock_pin_two_oe_q,
  .timeout_flag_q, .powerdown_flag_q, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready);

// file: core_model.sv
`timescale 1ns/1ns
module core_model (
  // Clock and core state
  input  wire logic mclk,
  input  wire logic core_hold_q,
  input  wire logic sys_tick_q,
  // Requests towards the sequencer
  output logic      sleep_req,
  output logic      watchdog_timeout,
  output logic      wake_irq,
  output logic      pin_two_gpio_out,
  output logic      pin_two_gpio_oe
);
  initial
  begin
    sleep_req = 1'b0;
    watchdog_timeout = 1'b0;
    wake_irq = 1'b0;
    pin_two_gpio_out = 1'b0;
    pin_two_gpio_oe = 1'b0;
  end
  // Kind 0 is a watchdog expiry, 1 a sleep request, 2 an interrupt wake
  // A held core cannot execute sleep, so that request is dropped then
  task automatic pulse(input logic [1:0] kind);
    @(posedge mclk);
    sleep_req <= (kind == 2'h1) && !core_hold_q;
    watchdog_timeout <= (kind == 2'h0);
    wake_irq <= (kind == 2'h2);
    @(posedge mclk);
    sleep_req <= 1'b0;
    watchdog_timeout <= 1'b0;
    wake_irq <= 1'b0;
  endtask
  // Only a running core drives pin two; a held core leaves it undriven
  always @(posedge mclk)
  begin
    pin_two_gpio_oe <= !core_hold_q;
    if (sys_tick_q && !core_hold_q)
      pin_two_gpio_out <= !pin_two_gpio_out;
  end
endmodule

// file: tb_reset_timeout_sequencer.sv
`timescale 1ns/1ns
`include "reset_timeout_sequencer_map.vh"
module tb_reset_timeout_sequencer;
  localparam int XHOLD = 200 + 2048;
  logic        mclk = 1'b0;
  logic        rst_n, brownout_low, master_clear_pin_n, brownout_enable;
  logic        powerup_timer_disable, clock_output_cfg, clock_input_pin = 1'b0;
  logic [2:0]  osc_mode;
  logic        psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, uq;
  wire  [31:0] prdata;
  wire         pready, pslverr, sleep_req, watchdog_timeout, wake_irq;
  wire         pin_two_gpio_out, pin_two_gpio_oe, clock_pin_two_out_q;
  wire         clock_pin_two_oe_q, core_hold_q, reg_clear_q, sys_tick_q;
  wire         timeout_flag_q, powerdown_flag_q;
  logic        ue;
  int          error_cnt = 0;
  int          check_count = 0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) clock_input_pin <= ~clock_input_pin;
  reset_timeout_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(32'd200), .SLOW_DIV(32'd20), .FAST_DIV(32'd4))
  reset_timeout_sequencer_i (.mclk, .rst_n, .brownout_low, .master_clear_pin_n,
    .watchdog_timeout, .wake_irq, .sleep_req, .osc_mode, .powerup_timer_disable,
    .brownout_enable, .clock_output_cfg, .clock_input_pin, .pin_two_gpio_out,
    .pin_two_gpio_oe, .clock_pin_two_out_q, .clock_pin_two_oe_q, .core_hold_q,
    .reg_clear_q, .sys_tick_q, .timeout_flag_q, .powerdown_flag_q, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  core_model core_model_i (.mclk, .core_hold_q, .sys_tick_q, .sleep_req,
    .watchdog_timeout, .wake_irq, .pin_two_gpio_out, .pin_two_gpio_oe);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Idle cycle first, so a back-to-back call never moves psel twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                    input string nm);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(nm, q & m, x);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic run_in(input string nm, input int lo, input int hi);
    int n;
    n = 0;
    while (core_hold_q !== 1'b0 && n < 5000)
    begin
      @(posedge mclk);
      n++;
    end
    cmp(nm, 32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic pin_low(input logic brownout_flag, input int n);
    if (brownout_flag)
      brownout_low <= 1'b1;
    else
      master_clear_pin_n <= 1'b0;
    repeat (n) @(posedge mclk);
    brownout_low <= 1'b0;
    master_clear_pin_n <= 1'b1;
    @(posedge mclk);
  endtask
  // Measures one high phase of pin two, in mclk cycles
  task automatic out_high(input string nm, input int exp);
    int g;
    g = 0;
    while (clock_pin_two_out_q !== 1'b0) @(posedge mclk);
    while (clock_pin_two_out_q !== 1'b1) @(posedge mclk);
    while (clock_pin_two_out_q === 1'b1 && g < 100)
    begin
      @(posedge mclk);
      g++;
    end
    cmp(nm, 32'(g), 32'(exp));
  endtask
  // The first gap after a speed change may be partial, so it is skipped
  task automatic tick_gap(input string nm, input int div);
    int g;
    g = 0;
    repeat (2)
    begin
      @(posedge mclk);
      while (sys_tick_q !== 1'b1) @(posedge mclk);
    end
    do
    begin
      @(posedge mclk);
      g++;
    end
    while (sys_tick_q !== 1'b1);
    cmp(nm, 32'(g), 32'(div));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    {rst_n, brownout_low, psel, penable, pwrite, clock_output_cfg} = 6'h00;
    {master_clear_pin_n, brownout_enable, powerup_timer_disable} = 3'b110;
    osc_mode = `MODE_XT;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    run_in("po_run", XHOLD - 4, XHOLD + 40);
    rd(`STAT_ADDR, 32'h83, 32'h03, "po_flags");
    rd(`POWER_CONTROL_STATUS_ADDR, 32'hff, 32'h08, "po_power_control_status");
    wr(`POWER_CONTROL_STATUS_ADDR, 32'h0b);
    rd(`POWER_CONTROL_STATUS_ADDR, 32'hff, 32'h0b, "power_control_status_rw");
    apb(1'b0, 12'h100, 32'h0, uq, ue);
    cmp("unmapped", {uq[30:0], ue}, 32'h1);
    $display("power-on test done");
    pin_low(1'b0, 10);
    cmp("glitch", 32'(core_hold_q), 32'h0);
    pin_low(1'b0, 40);
    cmp("master_clear_pin_clear", 32'(reg_clear_q), 32'h1);
    run_in("master_clear_pin_run", 0, 40);
    rd(`POWER_CONTROL_STATUS_ADDR, 32'hff, 32'h0b, "master_clear_pin_power_control_status");
    core_model_i.pulse(2'h0);
    repeat (4) @(posedge mclk);
    run_in("wdt_run", 0, 40);
    rd(`STAT_ADDR, 32'h83, 32'h02, "wdt_flags");
    $display("master clear and watchdog test done");
    core_model_i.pulse(2'h1);
    repeat (4) @(posedge mclk);
    rd(`STAT_ADDR, 32'h83, 32'h81, "sleep_flags");
    core_model_i.pulse(2'h0);
    run_in("wake_run", 2044, 2090);
    wr(`STAT_ADDR, 32'hff);
    rd(`STAT_ADDR, 32'h83, 32'h00, "wake_flags");
    core_model_i.pulse(2'h1);
    repeat (4) @(posedge mclk);
    core_model_i.pulse(2'h2);
    run_in("irq_run", 2044, 2090);
    rd(`STAT_ADDR, 32'h83, 32'h01, "irq_flags");
    $display("sleep test done");
    pin_low(1'b1, 40);
    repeat (100) @(posedge mclk);
    pin_low(1'b1, 40);
    run_in("bod_run", XHOLD - 4, XHOLD + 40);
    rd(`POWER_CONTROL_STATUS_ADDR, 32'hff, 32'h0a, "bod_power_control_status");
    brownout_enable <= 1'b0;
    pin_low(1'b1, 40);
    cmp("bod_off", 32'(core_hold_q), 32'h0);
    $display("brown-out test done");
    osc_mode <= `MODE_ER;
    clock_output_cfg <= 1'b1;
    repeat (6) @(posedge mclk);
    cmp("clock_output_oe", 32'(clock_pin_two_oe_q), 32'h1);
    out_high("clock_output_high", 8);
    clock_output_cfg <= 1'b0;
    repeat (6) @(posedge mclk);
    cmp("gpio_oe", 32'(clock_pin_two_oe_q), 32'h1);
    tick_gap("fast_gap", 4);
    wr(`POWER_CONTROL_STATUS_ADDR, 32'h03);
    tick_gap("slow_gap", 20);
    cmp("speed_run", 32'(core_hold_q), 32'h0);
    rd(`POWER_CONTROL_STATUS_ADDR, 32'hff, 32'h03, "speed_power_control_status");
    $display("clock option test done");
    powerup_timer_disable <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    run_in("rc_run", 0, 40);
    rd(`POWER_CONTROL_STATUS_ADDR, 32'hff, 32'h08, "rc_power_control_status");
    $display("rc power-on test done");
    stop_test();
  end
endmodule
